// ---- include/tots_pkg.sv ----
/*
 * Shared constants and state type of the timer output, tuned operation and capture selector.
 * Assumes an APB master with 32-bit data and 12-bit addresses.
 */
package tots_pkg;

	// ----------------------------------------------------------------
	// Sizes
	// ----------------------------------------------------------------
	localparam int unsigned NUM_TIMERS = 5;
	localparam int unsigned NUM_SLAVES = 3;
	localparam int unsigned MODE_W = 3;
	localparam int unsigned ADDR_W = 12;
	localparam int unsigned OCTL_W = 6;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [11:0] ADDR_CSS = 12'h000;
	localparam logic [11:0] ADDR_JOIN = 12'h004;
	localparam logic [11:0] ADDR_OCTL_BASE = 12'h010;
	localparam logic [11:0] ADDR_STATUS = 12'h030;
	localparam logic [7:0] CSS_RESET = 8'h00;
	localparam logic [2:0] JOIN_RESET = 3'h0;
	localparam logic [5:0] OCTL_RESET = 6'h00;
	localparam int CSS_RX0_BIT = 0;
	localparam int CSS_RX1_BIT = 1;
	localparam int CSS_ITV_BIT = 2;
	localparam int OE_LSB = 0;
	localparam int OL_LSB = 2;
	localparam int CMP_LSB = 4;
	localparam int STAT_JOIN_LSB = 10;

	// ----------------------------------------------------------------
	// Timer indices and mode field codes
	// ----------------------------------------------------------------
	localparam int T0 = 0;
	localparam int T2 = 2;
	localparam int SLV_IDX [NUM_SLAVES] = '{1, 3, 4};
	localparam int MST_IDX [NUM_SLAVES] = '{0, 2, 2};
	localparam logic [2:0] MODE_INTERVAL = 3'h0;
	localparam logic [2:0] MODE_EVENT = 3'h1;
	localparam logic [2:0] MODE_TRIGGER = 3'h2;
	localparam logic [2:0] MODE_ONESHOT = 3'h3;
	localparam logic [2:0] MODE_PWM = 3'h4;
	localparam logic [2:0] MODE_FREE = 3'h5;
	localparam logic [2:0] MODE_PULSE_WIDTH = 3'h6;
	localparam logic [2:0] MODE_TRI_PWM = 3'h7;

	typedef struct packed {
		logic [7:0] css;
		logic [2:0] join_en;
		logic [4:0][5:0] octl;
		logic ready;
		logic slverr;
		logic [31:0] rdata;
		logic [2:0] copy;
		logic [2:0] cap;
	} tots_top_t;

endpackage : tots_pkg

// ---- src/tots_sync.sv ----
/*
 * Three-stage pin synchroniser; a bit changes once stages two and three agree.
 * Assumes asynchronous inputs and a single system clock.
 */
`timescale 1ns/1ps
module tots_sync #(
	parameter int unsigned W = 3
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic [W-1:0] pin_in,
	output logic [W-1:0] level_out
);
	typedef struct packed {
		logic [W-1:0] q1;
		logic [W-1:0] q2;
		logic [W-1:0] q3;
		logic [W-1:0] level;
	} tots_sync_t;
	tots_sync_t s_reg;
	tots_sync_t s_next;

	always_comb begin
		s_next = s_reg;
		s_next.q1 = pin_in;
		s_next.q2 = s_reg.q1;
		s_next.q3 = s_reg.q2;
		s_next.level = (s_reg.q2 & ~(s_reg.q2 ^ s_reg.q3)) | (s_reg.level & (s_reg.q2 ^ s_reg.q3));
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign level_out = s_reg.level;
endmodule : tots_sync

// ---- src/tots_outctl.sv ----
/*
 * Two-channel timer output controller for one timer.
 * Assumes match and period events are one-cycle pulses from the counting logic.
 */
`timescale 1ns/1ps
module tots_outctl (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic [2:0] mode,
	input wire logic run_en,
	input wire logic tuned,
	input wire logic [1:0] oe,
	input wire logic [1:0] ol,
	input wire logic [1:0] cmp,
	input wire logic period_ev,
	input wire logic match0,
	input wire logic match1,
	output logic [1:0] pin_out
);
	typedef struct packed {
		logic run_q;
		logic [1:0] ph;
		logic [1:0] out;
	} tots_oc_t;
	tots_oc_t s_reg;
	tots_oc_t s_next;

	always_comb begin
		s_next = s_reg;
		s_next.run_q = run_en;
		unique case (mode)
			tots_pkg::MODE_INTERVAL, tots_pkg::MODE_EVENT, tots_pkg::MODE_TRI_PWM: begin
				s_next.ph[1] = s_reg.ph[1] ^ match1;
			end
			tots_pkg::MODE_TRIGGER: begin
				s_next.ph[1] = (s_reg.ph[1] | match1) & ~period_ev;
				s_next.ph[0] = s_reg.ph[0] ^ match0;
			end
			tots_pkg::MODE_ONESHOT: begin
				s_next.ph[1] = (s_reg.ph[1] | match1) & ~period_ev;
			end
			tots_pkg::MODE_PWM: begin
				s_next.ph[1] = (s_reg.ph[1] | match1) & ~period_ev;
				if (tuned) begin
					s_next.ph[0] = (s_reg.ph[0] | match0) & ~period_ev;
				end else begin
					s_next.ph[0] = s_reg.ph[0] ^ match0;
				end
			end
			tots_pkg::MODE_FREE: begin
				s_next.ph[1] = s_reg.ph[1] ^ (match1 & cmp[1]);
				s_next.ph[0] = s_reg.ph[0] ^ (match0 & cmp[0]);
			end
			tots_pkg::MODE_PULSE_WIDTH: begin
				s_next.ph = '0;
			end
		endcase
		if (run_en && !s_reg.run_q && mode != tots_pkg::MODE_PULSE_WIDTH) begin
			s_next.ph = 2'h3;
		end
		for (int c = 0; c < 2; c++) begin
			if (!oe[c] || !run_en) begin
				s_next.ph[c] = 1'b0;
			end
		end
		s_next.out = ol ^ s_next.ph;
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign pin_out = s_reg.out;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);

	a_level_when_off: assert property ((!oe[0] || !run_en) |=> pin_out[0] == $past(ol[0]))
		else $error("channel 0 not at level select while disabled");
	a_no_pw_wave: assert property ((mode == tots_pkg::MODE_PULSE_WIDTH) |=> pin_out == $past(ol))
		else $error("waveform driven in pulse width mode");
endmodule : tots_outctl

// ---- src/tots_top.sv ----
/*
 * Timer output control, tuned master/slave operation and capture source selector.
 * Assumes counting logic outside supplies mode fields, run enables and match pulses,
 * and that software reaches the registers over APB.
 */
// The placing of the registers and the APB register port were left to the implementer.
`timescale 1ns/1ps

// Notes on behaviour
// - Disabled output drives its level select.
// - Enabled output flips level when counting starts, except in pulse width mode.
// - Interval and event modes give square wave on channel one.
// - Trigger mode: pulse on one, square zero.
// - One-shot and PWM pulses on channel one.
// - Free-running toggles only compare channels.
// - Pulse width mode drives no waveform.
// - Master zero pairs slave one; two drives three, aux.
// - Slave joins only while its join bit set.
// - Masters run free or PWM, never triangular.
// - Free-running copies compare on processor write.
// - PWM mode copies compare on channel-zero match.
// - Slave one captures selectable from serial receive.
// - Master zero capture one selectable from interval match.
// - Eight-bit selector register, reset zero, byte writable.
// - Slow clock early capture may read all ones.
// - Counter starts when run enable is set.
module tots_top (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	input wire logic [14:0] mode_field,
	input wire logic [4:0] count_run_enable,
	input wire logic [4:0] match0,
	input wire logic [4:0] match1,
	input wire logic [4:0] master_cc_write,
	input wire logic capture_in_1_0,
	input wire logic capture_in_1_1,
	input wire logic capture_in_0_1,
	input wire logic serial_rx_0,
	input wire logic serial_rx_1,
	input wire logic interval_match_event,
	output logic [4:0] timer_out_ch0,
	output logic [4:0] timer_out_ch1,
	output logic [2:0] compare_copy,
	output logic capture_sel_1_0,
	output logic capture_sel_1_1,
	output logic capture_sel_0_1
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	tots_pkg::tots_top_t s_reg;
	tots_pkg::tots_top_t s_next;
	logic [4:0] pin_sync;
	logic [4:0][1:0] pins;
	logic [4:0][2:0] eff_mode;
	logic [4:0] eff_period;
	logic [4:0] eff_tuned;
	logic [2:0] tuned_active;
	logic [2:0] copy_ev;
	logic [11:0] octl_off;
	logic [2:0] octl_idx;
	logic octl_hit;
	logic setup_ph;
	logic wr_take;

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	// The interval match event is on this clock and needs no stages.
	tots_sync #(
		.W(5)
	) u_sync (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.pin_in({serial_rx_1, serial_rx_0, capture_in_0_1, capture_in_1_1, capture_in_1_0}),
		.level_out(pin_sync)
	);

	// ----------------------------------------------------------------
	// Tuned master and slave coupling
	// ----------------------------------------------------------------
	always_comb begin
		tuned_active = '0;
		copy_ev = '0;
		for (int t = 0; t < tots_pkg::NUM_TIMERS; t++) begin
			eff_mode[t] = mode_field[t*tots_pkg::MODE_W +: tots_pkg::MODE_W];
			eff_period[t] = match0[t];
			eff_tuned[t] = 1'b0;
		end
		for (int k = 0; k < tots_pkg::NUM_SLAVES; k++) begin
			tuned_active[k] = s_reg.join_en[k]
				&& (eff_mode[tots_pkg::MST_IDX[k]] == tots_pkg::MODE_FREE
				|| eff_mode[tots_pkg::MST_IDX[k]] == tots_pkg::MODE_PWM);
			if (tuned_active[k]) begin
				if (eff_mode[tots_pkg::MST_IDX[k]] == tots_pkg::MODE_FREE) begin
					copy_ev[k] = master_cc_write[tots_pkg::MST_IDX[k]];
				end else begin
					copy_ev[k] = match0[tots_pkg::MST_IDX[k]];
				end
			end
		end
		for (int k = 0; k < tots_pkg::NUM_SLAVES; k++) begin
			if (tuned_active[k]) begin
				eff_mode[tots_pkg::SLV_IDX[k]] = eff_mode[tots_pkg::MST_IDX[k]];
				eff_period[tots_pkg::SLV_IDX[k]] = match0[tots_pkg::MST_IDX[k]];
				eff_tuned[tots_pkg::SLV_IDX[k]] = 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Output controllers
	// ----------------------------------------------------------------
	// counter start from run enable
	for (genvar g = 0; g < tots_pkg::NUM_TIMERS; g++) begin : g_out
		tots_outctl u_oc (
			.sys_clk(sys_clk),
			.sys_rst(sys_rst),
			.mode(eff_mode[g]),
			.run_en(count_run_enable[g]),
			.tuned(eff_tuned[g]),
			.oe(s_reg.octl[g][tots_pkg::OE_LSB +: 2]),
			.ol(s_reg.octl[g][tots_pkg::OL_LSB +: 2]),
			.cmp(s_reg.octl[g][tots_pkg::CMP_LSB +: 2]),
			.period_ev(eff_period[g]),
			.match0(match0[g]),
			.match1(match1[g]),
			.pin_out(pins[g])
		);
		assign timer_out_ch0[g] = pins[g][0];
		assign timer_out_ch1[g] = pins[g][1];
	end

	// ----------------------------------------------------------------
	// Register decode
	// ----------------------------------------------------------------
	assign octl_off = paddr - tots_pkg::ADDR_OCTL_BASE;
	assign octl_idx = octl_off[4:2];
	assign octl_hit = (paddr >= tots_pkg::ADDR_OCTL_BASE) && (octl_off[11:5] == 7'h00)
		&& (octl_off[1:0] == 2'h0) && (octl_idx < 3'(tots_pkg::NUM_TIMERS));
	assign setup_ph = psel && !penable;
	assign wr_take = psel && penable && s_reg.ready && pwrite;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		s_next = s_reg;
		s_next.ready = 1'b0;
		s_next.slverr = 1'b0;
		// Answer one cycle after setup, so the access phase takes a single cycle.
		if (setup_ph) begin
			s_next.ready = 1'b1;
			s_next.rdata = '0;
			if (paddr == tots_pkg::ADDR_CSS) begin
				s_next.rdata[7:0] = s_reg.css;
			end else if (paddr == tots_pkg::ADDR_JOIN) begin
				s_next.rdata[2:0] = s_reg.join_en;
			end else if (paddr == tots_pkg::ADDR_STATUS) begin
				s_next.rdata[9:0] = {timer_out_ch1, timer_out_ch0};
				s_next.rdata[tots_pkg::STAT_JOIN_LSB +: 3] = tuned_active;
			end else if (octl_hit) begin
				s_next.rdata[5:0] = s_reg.octl[octl_idx];
			end else begin
				s_next.slverr = 1'b1;
			end
		end else if (psel && penable && s_reg.ready) begin
			s_next.rdata = s_reg.rdata;
		end
		// Writes land only on byte lane zero; the status word is read only.
		if (wr_take && pstrb[0]) begin
			if (paddr == tots_pkg::ADDR_CSS) begin
				s_next.css = pwdata[7:0];
			end else if (paddr == tots_pkg::ADDR_JOIN) begin
				s_next.join_en = pwdata[2:0];
			end else if (octl_hit) begin
				s_next.octl[octl_idx] = pwdata[5:0];
			end
		end
		s_next.copy = copy_ev;
		s_next.cap[0] = s_reg.css[tots_pkg::CSS_RX0_BIT] ? pin_sync[3] : pin_sync[0];
		s_next.cap[1] = s_reg.css[tots_pkg::CSS_RX1_BIT] ? pin_sync[4] : pin_sync[1];
		s_next.cap[2] = s_reg.css[tots_pkg::CSS_ITV_BIT] ? interval_match_event : pin_sync[2];
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			s_reg.css <= tots_pkg::CSS_RESET;
			s_reg.join_en <= tots_pkg::JOIN_RESET;
			s_reg.octl <= {tots_pkg::NUM_TIMERS{tots_pkg::OCTL_RESET}};
			s_reg.ready <= 1'b0;
			s_reg.slverr <= 1'b0;
			s_reg.rdata <= 32'h0000_0000;
			s_reg.copy <= 3'h0;
			s_reg.cap <= 3'h0;
		end else begin
			s_reg <= s_next;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// pin capture paths add five register stages
	// A capture pulse right after the run enable rises can therefore meet a counter
	// that has not yet left its idle all-ones value.
	assign capture_sel_1_0 = s_reg.cap[0];
	assign capture_sel_1_1 = s_reg.cap[1];
	assign capture_sel_0_1 = s_reg.cap[2];
	assign compare_copy = s_reg.copy;
	assign pready = s_reg.ready;
	assign prdata = s_reg.rdata;
	assign pslverr = s_reg.slverr;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);

	sequence apb_setup;
		psel && !penable;
	endsequence

	sequence apb_access;
		psel && penable && pready;
	endsequence

	sequence css_write;
		psel && penable && pready && pwrite && pstrb[0] && paddr == tots_pkg::ADDR_CSS;
	endsequence

	a_apb_ready_next: assert property (apb_setup |=> pready)
		else $error("pready not given one cycle after setup");
	a_css_write_takes: assert property (css_write |=> s_reg.css == $past(pwdata[7:0]))
		else $error("selector write lost");
	a_css_readback: assert property (apb_setup ##1 (apb_access and (!pwrite
		&& $past(paddr) == tots_pkg::ADDR_CSS)) |-> prdata[7:0] == s_reg.css)
		else $error("selector read wrong");
	a_rx0_route: assert property (s_reg.css[tots_pkg::CSS_RX0_BIT]
		|=> capture_sel_1_0 == $past(pin_sync[3]))
		else $error("serial receive 0 not routed");
	a_itv_route: assert property (s_reg.css[tots_pkg::CSS_ITV_BIT]
		|=> capture_sel_0_1 == $past(interval_match_event))
		else $error("interval match not routed");
	a_copy_on_write: assert property (s_reg.join_en[0] && master_cc_write[tots_pkg::T0]
		&& mode_field[2:0] == tots_pkg::MODE_FREE |=> compare_copy[0])
		else $error("free-running copy missed");
	a_copy_on_match: assert property (s_reg.join_en[1] && match0[tots_pkg::T2]
		&& mode_field[8:6] == tots_pkg::MODE_PWM |=> compare_copy[1])
		else $error("PWM copy missed");
	a_no_tri_copy: assert property (mode_field[8:6] == tots_pkg::MODE_TRI_PWM
		|=> compare_copy[2:1] == 2'h0)
		else $error("triangular master copied");
	a_join_off: assert property (!s_reg.join_en[2] |=> !compare_copy[2])
		else $error("slave tuned without join bit");
	a_pair_fixed: assert property (compare_copy[0] |-> $past(match0[tots_pkg::T0]
		|| master_cc_write[tots_pkg::T0]))
		else $error("slave one copied from wrong master");
	a_unmapped_err: assert property (apb_setup and (paddr == 12'h03C) |=> pslverr)
		else $error("unmapped address not flagged");
endmodule : tots_top

// ---- bench/tots_far_side.sv ----
/*
 * Behavioural model of the counting logic beside the block: per-timer match pulses.
 * Assumes the bench gates pulse generation and drives the run enables.
 */
`timescale 1ns/1ps
module tots_far_side (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic [4:0] count_run_enable,
	input wire logic pulse_en,
	output logic [4:0] match0,
	output logic [4:0] match1
);
	logic [4:0][3:0] cnt_reg;

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			cnt_reg <= '0;
			match0 <= '0;
			match1 <= '0;
		end else begin
			for (int t = 0; t < 5; t++) begin
				cnt_reg[t] <= !count_run_enable[t] ? 4'h0 : (cnt_reg[t] == 4'hB) ? 4'h0 :
					cnt_reg[t] + 4'h1;
				match1[t] <= pulse_en && count_run_enable[t] && cnt_reg[t] == 4'h5;
				match0[t] <= pulse_en && count_run_enable[t] && cnt_reg[t] == 4'hB;
			end
		end
	end
endmodule : tots_far_side

// ---- bench/test_timer_output_tuning_selector.sv ----
/*
 * Self-checking bench: pin waveforms per mode, tuned compare copies, capture routing.
 * Assumes the package, the design and the far-side model are compiled first.
 */
`timescale 1ns/1ps
module test_timer_output_tuning_selector;
	localparam logic [2:0] FR = tots_pkg::MODE_FREE;
	localparam logic [2:0] PW = tots_pkg::MODE_PWM;
	logic sys_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, er;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd;
	logic [31:0] seed = 32'h1190;
	logic [3:0] pstrb = '0;
	logic [14:0] mode_field = '0;
	logic [4:0] run_en = '0, mcw = '0, m0, m1, ch0, ch1;
	logic cap10 = 1'b0, cap11 = 1'b0, cap01 = 1'b0, rx0 = 1'b0, rx1 = 1'b0, ime = 1'b0;
	logic pulse_en = 1'b0, sel10, sel11, sel01;
	logic [2:0] ccopy;
	logic [2:0] jn [3] = '{3'h7, 3'h5, 3'h7};
	logic [2:0] ma [3] = '{FR, PW, PW};
	logic [2:0] mb [3] = '{PW, FR, tots_pkg::MODE_TRI_PWM};
	int err_count = 0, comparisons = 0, tg0, tg1, cm1;
	int cm0 [5];
	int cc [3];

	always #2.5 sys_clk = ~sys_clk;

	tots_top DUT (.sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .mode_field(mode_field),
		.count_run_enable(run_en), .match0(m0), .match1(m1), .master_cc_write(mcw),
		.capture_in_1_0(cap10), .capture_in_1_1(cap11), .capture_in_0_1(cap01),
		.serial_rx_0(rx0), .serial_rx_1(rx1), .interval_match_event(ime),
		.timer_out_ch0(ch0), .timer_out_ch1(ch1), .compare_copy(ccopy),
		.capture_sel_1_0(sel10), .capture_sel_1_1(sel11), .capture_sel_0_1(sel01));

	tots_far_side far (.sys_clk(sys_clk), .sys_rst(sys_rst), .count_run_enable(run_en),
		.pulse_en(pulse_en), .match0(m0), .match1(m1));

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	// Expected pin edges in a run; -1 where the waveform is not predicted.
	function automatic int exp_tog(input logic [2:0] md, input logic ch, input logic oe,
		input logic cmp, input int m);
		if (!oe || md == tots_pkg::MODE_PULSE_WIDTH) return 0;
		case (md)
			tots_pkg::MODE_INTERVAL, tots_pkg::MODE_EVENT, tots_pkg::MODE_TRI_PWM: begin
				return ch ? m + 1 : 1;
			end
			tots_pkg::MODE_TRIGGER, PW: return ch ? -1 : m + 1;
			FR: return cmp ? m + 1 : 1;
			default: return ch ? -1 : 1;
		endcase
	endfunction : exp_tog

	function automatic int exp_copy(input logic joined, input logic [2:0] mm, input int m);
		if (!joined) return 0;
		if (mm == FR) return 1;
		return (mm == PW) ? m : 0;
	endfunction : exp_copy

	task automatic conclude();
		$display("Comparisons %0d, mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : conclude

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
		input logic [3:0] st);
		int n;
		n = 0;
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		pstrb <= st;
		@(posedge sys_clk);
		penable <= 1'b1;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			err_count++;
			conclude();
		end
	endtask : apb

	// Counts causes and pin edges of timer t; pulses stop after n cycles.
	task automatic watch(input int t, input int n);
		logic p0, p1;
		tg0 = 0;
		tg1 = 0;
		cm1 = 0;
		cm0 = '{default: 0};
		cc = '{default: 0};
		pulse_en <= 1'b1;
		@(posedge sys_clk);
		mcw <= '0;
		p0 = ch0[t];
		p1 = ch1[t];
		for (int i = 0; i < n + 5; i++) begin
			@(posedge sys_clk);
			if (i == n) pulse_en <= 1'b0;
			for (int k = 0; k < 5; k++) cm0[k] += int'(m0[k]);
			for (int k = 0; k < 3; k++) cc[k] += int'(ccopy[k]);
			cm1 += int'(m1[t]);
			tg0 += int'(ch0[t] !== p0);
			tg1 += int'(ch1[t] !== p1);
			p0 = ch0[t];
			p1 = ch1[t];
		end
	endtask : watch

	initial begin
		int t, e;
		logic [5:0] oct;
		logic [2:0] md;
		repeat (3) @(posedge sys_clk);
		sys_rst <= 1'b0;
		apb(1'b0, tots_pkg::ADDR_CSS, '0, 4'hF);
		check(rd, 32'h0000_0000);
		apb(1'b0, 12'h03C, '0, 4'hF);
		check({rd[30:0], er}, 32'h0000_0001);
		// ----------------------------------------------------------------
		// Pin waveform in every counting mode
		// ----------------------------------------------------------------
		for (int k = 0; k < 16; k++) begin
			seed = lfsr(seed);
			t = int'(seed[10:8]) % 5;
			md = 3'(k % 8);
			oct = seed[5:0] | (k < 8 ? 6'h03 : 6'h00);
			apb(1'b1, tots_pkg::ADDR_OCTL_BASE + 12'(4 * t), {26'h0, oct}, 4'hF);
			mode_field[3 * t +: 3] <= md;
			@(posedge sys_clk);
			run_en[t] <= 1'b1;
			watch(t, 36);
			e = exp_tog(md, 1'b0, oct[0], oct[4], cm0[t]);
			if (e >= 0) check(tg0, e);
			e = exp_tog(md, 1'b1, oct[1], oct[5], cm1);
			if (e >= 0) check(tg1, e);
			run_en[t] <= 1'b0;
			repeat (3) @(posedge sys_clk);
			check({ch1[t], ch0[t]}, oct[3:2]);
		end
		// ----------------------------------------------------------------
		// Tuned operation: copies by mode and join bit
		// ----------------------------------------------------------------
		for (int c = 0; c < 3; c++) begin
			apb(1'b1, tots_pkg::ADDR_JOIN, {29'h0, jn[c]}, 4'hF);
			apb(1'b0, tots_pkg::ADDR_JOIN, '0, 4'hF);
			check(rd, {29'h0, jn[c]});
			mode_field <= {FR, FR, mb[c], FR, ma[c]};
			@(posedge sys_clk);
			run_en <= 5'b11010;
			@(posedge sys_clk);
			run_en <= 5'h1F;
			mcw <= 5'b00101;
			watch(0, 36);
			check(cc[0], exp_copy(jn[c][0], ma[c], cm0[0]));
			check(cc[1], exp_copy(jn[c][1], mb[c], cm0[2]));
			check(cc[2], exp_copy(jn[c][2], mb[c], cm0[2]));
			apb(1'b0, tots_pkg::ADDR_STATUS, '0, 4'hF);
			check(rd[12:10], {jn[c][2:1] & {2{mb[c] != tots_pkg::MODE_TRI_PWM}}, jn[c][0]});
			run_en <= '0;
		end
		mode_field <= '0;
		// ----------------------------------------------------------------
		// Capture source selector
		// ----------------------------------------------------------------
		for (int k = 0; k < 6; k++) begin
			seed = lfsr(seed);
			{rx0, rx1, ime} <= 3'b000;
			apb(1'b1, tots_pkg::ADDR_CSS, seed, 4'hF);
			apb(1'b0, tots_pkg::ADDR_CSS, '0, 4'hF);
			check(rd, {24'h0, seed[7:0]});
			{cap10, cap11, cap01, rx0, rx1, ime} <= seed[15:10];
			repeat (8) @(posedge sys_clk);
			check(sel10, seed[0] ? rx0 : cap10);
			check(sel11, seed[1] ? rx1 : cap11);
			check(sel01, seed[2] ? ime : cap01);
		end
		apb(1'b1, tots_pkg::ADDR_CSS, ~seed, 4'hE);
		apb(1'b0, tots_pkg::ADDR_CSS, '0, 4'hF);
		check(rd, {24'h0, seed[7:0]});
		conclude();
	end
endmodule : test_timer_output_tuning_selector
